// *** src/srcs_regs.svh ***
// register indices, field positions, reset values and cycle counts
`ifndef SRCS_REGS_SVH
`define SRCS_REGS_SVH

// ****************************************************************
// register word indices (byte address = 4 * index)
// ****************************************************************
`define SRCS_IDX_BRK_STATUS   16'hfe00
`define SRCS_IDX_RST_CAUSE    16'hfe01
`define SRCS_IDX_BRK_FLAG_CTL 16'hfe03
`define SRCS_IDX_SEQ_CTRL     16'hfe04

// ****************************************************************
// field positions
// ****************************************************************
`define SRCS_BIT_POR          7
`define SRCS_BIT_PIN          6
`define SRCS_BIT_WDOG         5
`define SRCS_BIT_BAD_OP       4
`define SRCS_BIT_BAD_ADR      3
`define SRCS_BIT_BROWNOUT     1
`define SRCS_BIT_BRK_WAIT     1
`define SRCS_BIT_BRK_CLR_EN   7
`define SRCS_BIT_SHORT_STOP   0

// ****************************************************************
// reset values and vectors
// ****************************************************************
`define SRCS_CAUSE_POR_ONLY   8'h80
`define SRCS_VEC_USER         16'hfffe
`define SRCS_VEC_MONITOR      16'hfefe

// ****************************************************************
// cycle counts of the reference clock
// ****************************************************************
`define SRCS_POR_HOLD_CYC     13'h1000
`define SRCS_STOP_LONG_CYC    13'h1000
`define SRCS_STOP_SHORT_CYC   13'h0020
`define SRCS_PIN_DRIVE_CYC    6'h20
`define SRCS_INTERNAL_RESET_TAIL_CYC    6'h20
`define SRCS_PIN_MIN_CYC      13'h0043
`define SRCS_PIN_MIN_POR_CYC  13'h1043
`define SRCS_LOW_CNT_MAX      13'h1fff
`define SRCS_BUS_DIV_LAST     2'h3

`endif

// *** src/srcs_pkg.sv ***
// types shared by the reset and clock sequencer
package srcs_pkg;

    // ************************************************************
    // sequencer states
    // ************************************************************
    typedef enum logic [2:0] {
        SRCS_RUN       = 3'b000,
        SRCS_POR_HOLD  = 3'b001,
        SRCS_DRIVE     = 3'b010,
        SRCS_TAIL      = 3'b011,
        SRCS_EXT_LOW   = 3'b100,
        SRCS_STOP      = 3'b101,
        SRCS_STOP_EXIT = 3'b110
    } srcs_state_t;

    // ************************************************************
    // asynchronous inputs after the synchroniser
    // ************************************************************
    typedef struct packed {
        logic power_on;
        logic brownout;
        logic watchdog;
        logic pin_high;
    } srcs_async_t;

endpackage

// *** src/srcs_sync.sv ***
// two flip-flop synchroniser, one stage pair per bit
`timescale 1ns/1ns
module srcs_sync #(
    parameter int       W       = 4,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    // data
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);

    initial
    begin
        if (W < 1) $error("srcs_sync: width must be at least one");
    end

    genvar g;
    generate
        for (g = 0; g < W; g++)
        begin : g_bit
            logic meta_q;
            logic sync_q;
            always_ff @(posedge clk_i)
            begin
                if (rst_i)
                begin
                    meta_q <= RST_VAL[g];
                    sync_q <= RST_VAL[g];
                end
                else
                begin
                    meta_q <= d_i[g];
                    sync_q <= meta_q;
                end
            end
            assign q_o[g] = sync_q;
        end
    endgenerate

endmodule // srcs_sync

// *** src/srcs_top.sv ***
// reset and clock sequencer with classic wishbone register slave
`timescale 1ns/1ns
`include "srcs_regs.svh"
module srcs_top #(
    parameter int ADR_W = 16
) (
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    // wishbone slave
    input  wire logic             wb_cyc_i,
    input  wire logic             wb_stb_i,
    input  wire logic             wb_we_i,
    input  wire logic [ADR_W+1:0] wb_adr_i,
    input  wire logic [3:0]       wb_sel_i,
    input  wire logic [31:0]      wb_dat_i,
    output logic      [31:0]      wb_dat_o,
    output logic                  wb_ack_o,
    // reset sources
    input  wire logic             power_on_pulse_i,
    input  wire logic             brownout_cause_i,
    input  wire logic             watchdog_cause_i,
    input  wire logic             bad_opcode_cause_i,
    input  wire logic             bad_address_cause_i,
    input  wire logic             opcode_fetch_i,
    // reset pin
    input  wire logic             reset_pin_i,
    output logic                  reset_pin_o,
    output logic                  reset_pin_oe_o,
    // cpu and mode inputs
    input  wire logic             stop_req_i,
    input  wire logic             wake_i,
    input  wire logic             wait_i,
    input  wire logic             periph_wait_run_i,
    input  wire logic             monitor_mode_i,
    input  wire logic             break_wait_set_i,
    // outputs to the system
    output logic                  internal_reset_o,
    output logic [15:0]           reset_vector_o,
    output logic                  cpu_clk_en_o,
    output logic                  periph_clk_en_o,
    output logic                  break_clear_enable_o
);

    initial
    begin
        if (ADR_W < 16) $error("srcs_top: ADR_W must be at least 16");
    end

    // ************************************************************
    // input synchroniser
    // ************************************************************
    srcs_pkg::srcs_async_t async_s;

    srcs_sync #(
        .W       (4),
        .RST_VAL (4'h1)
    ) u_sync (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .d_i   ({power_on_pulse_i, brownout_cause_i,
                 watchdog_cause_i, reset_pin_i}),
        .q_o   (async_s)
    );

    logic pin_low_s;
    assign pin_low_s = ~async_s.pin_high;

    // ************************************************************
    // sequencer state
    // ************************************************************
    srcs_pkg::srcs_state_t st_q, st_d;
    logic [11:0] stab_q, stab_d;
    logic [5:0]  seq_q, seq_d;
    logic [12:0] low_q, low_d;
    logic        por_org_q, por_org_d;
    logic [7:0]  cause_q, cause_d;
    logic [1:0]  div_q, div_d;
    logic        internal_reset_q, internal_reset_d;
    logic        pin_oe_q, pin_oe_d;
    logic        cpu_en_q, cpu_en_d;
    logic        per_en_q, per_en_d;
    logic [15:0] vec_q, vec_d;
    logic        short_stop_recovery_q;
    logic        int_src;
    logic        run_d;
    logic [12:0] stop_lim;
    logic [12:0] pin_thr;

    always_comb
    begin
        int_src  = async_s.watchdog | bad_opcode_cause_i
                 | (bad_address_cause_i & opcode_fetch_i);
        stop_lim = short_stop_recovery_q ? `SRCS_STOP_SHORT_CYC
                           : `SRCS_STOP_LONG_CYC;
        pin_thr  = por_org_q ? `SRCS_PIN_MIN_POR_CYC
                             : `SRCS_PIN_MIN_CYC;
        st_d      = st_q;
        stab_d    = stab_q + 12'h001;
        seq_d     = seq_q + 6'h01;
        por_org_d = por_org_q;
        cause_d   = cause_q;
        // low time of the pin
        if (pin_low_s)
            low_d = (low_q == `SRCS_LOW_CNT_MAX) ? low_q : low_q + 13'h0001;
        else
            low_d = 13'h0000;
        if (pin_low_s && (low_q == pin_thr - 13'h0001))
            cause_d[`SRCS_BIT_PIN] = 1'b1;
        case (st_q)
            srcs_pkg::SRCS_RUN:
            begin
                if (stop_req_i)
                begin
                    st_d   = srcs_pkg::SRCS_STOP;
                    stab_d = 12'h000;
                end
            end
            srcs_pkg::SRCS_STOP:
            begin
                if (wake_i)
                begin
                    st_d   = srcs_pkg::SRCS_STOP_EXIT;
                    stab_d = 12'h000;
                end
            end
            srcs_pkg::SRCS_STOP_EXIT:
            begin
                if ({1'b0, stab_q} == stop_lim - 13'h0001)
                    st_d = srcs_pkg::SRCS_RUN;
            end
            srcs_pkg::SRCS_POR_HOLD:
            begin
                if ({1'b0, stab_q} == `SRCS_POR_HOLD_CYC - 13'h0001)
                begin
                    st_d  = srcs_pkg::SRCS_DRIVE;
                    seq_d = 6'h00;
                end
            end
            srcs_pkg::SRCS_DRIVE:
            begin
                if (seq_q == `SRCS_PIN_DRIVE_CYC - 6'h01)
                begin
                    st_d  = srcs_pkg::SRCS_TAIL;
                    seq_d = 6'h00;
                end
            end
            srcs_pkg::SRCS_TAIL:
            begin
                if (seq_q == `SRCS_INTERNAL_RESET_TAIL_CYC - 6'h01)
                begin
                    if (pin_low_s)
                        st_d = srcs_pkg::SRCS_EXT_LOW;
                    else
                    begin
                        st_d      = srcs_pkg::SRCS_RUN;
                        por_org_d = 1'b0;
                    end
                end
            end
            srcs_pkg::SRCS_EXT_LOW:
            begin
                if (!pin_low_s)
                begin
                    st_d  = srcs_pkg::SRCS_TAIL;
                    seq_d = 6'h00;
                end
            end
            default:
            begin
                st_d = srcs_pkg::SRCS_RUN;
            end
        endcase
        // reset sources override the sequence
        if (async_s.watchdog)
            cause_d[`SRCS_BIT_WDOG] = 1'b1;
        if (bad_opcode_cause_i)
            cause_d[`SRCS_BIT_BAD_OP] = 1'b1;
        if (bad_address_cause_i && opcode_fetch_i)
            cause_d[`SRCS_BIT_BAD_ADR] = 1'b1;
        if (async_s.brownout)
            cause_d[`SRCS_BIT_BROWNOUT] = 1'b1;
        if (async_s.power_on)
            cause_d = `SRCS_CAUSE_POR_ONLY;
        if (async_s.power_on || async_s.brownout)
        begin
            st_d      = srcs_pkg::SRCS_POR_HOLD;
            stab_d    = 12'h000;
            por_org_d = 1'b1;
        end
        else if (int_src)
        begin
            st_d   = srcs_pkg::SRCS_DRIVE;
            seq_d  = 6'h00;
            stab_d = 12'h000;
        end
        else if (pin_low_s && (st_q == srcs_pkg::SRCS_RUN
                 || st_q == srcs_pkg::SRCS_STOP
                 || st_q == srcs_pkg::SRCS_STOP_EXIT))
            st_d = srcs_pkg::SRCS_EXT_LOW;
        // registered reset, pin enable and clock outputs follow the next state
        run_d    = (st_d == srcs_pkg::SRCS_RUN);
        internal_reset_d   = (st_d == srcs_pkg::SRCS_POR_HOLD)
                 || (st_d == srcs_pkg::SRCS_DRIVE)
                 || (st_d == srcs_pkg::SRCS_TAIL)
                 || (st_d == srcs_pkg::SRCS_EXT_LOW);
        pin_oe_d = (st_d == srcs_pkg::SRCS_POR_HOLD)
                 || (st_d == srcs_pkg::SRCS_DRIVE);
        div_d    = div_q + 2'h1;
        cpu_en_d = (div_q == `SRCS_BUS_DIV_LAST) && run_d
                 && !wait_i;
        per_en_d = (div_q == `SRCS_BUS_DIV_LAST) && run_d
                 && (!wait_i || periph_wait_run_i);
        vec_d    = monitor_mode_i ? `SRCS_VEC_MONITOR
                                  : `SRCS_VEC_USER;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            st_q      <= srcs_pkg::SRCS_POR_HOLD;
            stab_q    <= 12'h000;
            seq_q     <= 6'h00;
            low_q     <= 13'h0000;
            por_org_q <= 1'b1;
            cause_q   <= `SRCS_CAUSE_POR_ONLY;
            div_q     <= 2'h0;
            internal_reset_q    <= 1'b1;
            pin_oe_q  <= 1'b1;
            cpu_en_q  <= 1'b0;
            per_en_q  <= 1'b0;
            vec_q     <= `SRCS_VEC_USER;
        end
        else
        begin
            st_q      <= st_d;
            stab_q    <= stab_d;
            seq_q     <= seq_d;
            low_q     <= low_d;
            por_org_q <= por_org_d;
            cause_q   <= cause_d;
            div_q     <= div_d;
            internal_reset_q    <= internal_reset_d;
            pin_oe_q  <= pin_oe_d;
            cpu_en_q  <= cpu_en_d;
            per_en_q  <= per_en_d;
            vec_q     <= vec_d;
        end
    end

    // ************************************************************
    // wishbone register slave
    // ************************************************************
    logic [ADR_W-1:0] idx;
    logic        hit, wr0;
    logic        ack_q, ack_d;
    logic [31:0] dat_q, dat_d;
    logic        bsw_q, bsw_d;
    logic        break_clear_enable_q, break_clear_enable_d;
    logic        short_stop_recovery_d;

    always_comb
    begin
        idx     = wb_adr_i[ADR_W+1:2];
        hit     = wb_cyc_i && wb_stb_i && !ack_q;
        wr0     = hit && wb_we_i && wb_sel_i[0];
        ack_d   = hit;
        dat_d   = 32'h0000_0000;
        bsw_d   = bsw_q;
        break_clear_enable_d  = break_clear_enable_q;
        short_stop_recovery_d = short_stop_recovery_q;
        if (hit && !wb_we_i)
        begin
            case (idx)
                ADR_W'(`SRCS_IDX_BRK_STATUS):
                    dat_d[`SRCS_BIT_BRK_WAIT] = bsw_q;
                ADR_W'(`SRCS_IDX_RST_CAUSE):
                    dat_d[7:0] = cause_q;
                ADR_W'(`SRCS_IDX_BRK_FLAG_CTL):
                    dat_d[`SRCS_BIT_BRK_CLR_EN] = break_clear_enable_q;
                ADR_W'(`SRCS_IDX_SEQ_CTRL):
                    dat_d[`SRCS_BIT_SHORT_STOP] = short_stop_recovery_q;
                default:
                    dat_d = 32'h0000_0000;
            endcase
        end
        if (wr0 && idx == ADR_W'(`SRCS_IDX_BRK_STATUS)
            && !wb_dat_i[`SRCS_BIT_BRK_WAIT])
            bsw_d = 1'b0;
        if (break_wait_set_i)
            bsw_d = 1'b1;
        if (wr0 && idx == ADR_W'(`SRCS_IDX_BRK_FLAG_CTL))
            break_clear_enable_d = wb_dat_i[`SRCS_BIT_BRK_CLR_EN];
        if (wr0 && idx == ADR_W'(`SRCS_IDX_SEQ_CTRL))
            short_stop_recovery_d = wb_dat_i[`SRCS_BIT_SHORT_STOP];
        if (internal_reset_q)
        begin
            bsw_d   = 1'b0;
            break_clear_enable_d  = 1'b0;
            short_stop_recovery_d = 1'b0;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_q   <= 1'b0;
            dat_q   <= 32'h0000_0000;
            bsw_q   <= 1'b0;
            break_clear_enable_q  <= 1'b0;
            short_stop_recovery_q <= 1'b0;
        end
        else
        begin
            ack_q   <= ack_d;
            dat_q   <= dat_d;
            bsw_q   <= bsw_d;
            break_clear_enable_q  <= break_clear_enable_d;
            short_stop_recovery_q <= short_stop_recovery_d;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    logic pin_out_q;

    always_ff @(posedge clk_i)
    begin
        pin_out_q <= 1'b0;
    end

    assign wb_ack_o             = ack_q;
    assign wb_dat_o             = dat_q;
    assign reset_pin_o          = pin_out_q;
    assign reset_pin_oe_o       = pin_oe_q;
    assign internal_reset_o     = internal_reset_q;
    assign reset_vector_o       = vec_q;
    assign cpu_clk_en_o         = cpu_en_q;
    assign periph_clk_en_o      = per_en_q;
    assign break_clear_enable_o = break_clear_enable_q;

endmodule // srcs_top

// *** bench/srcs_pin_model.sv ***
// far-side reset circuitry on the shared reset wire
`timescale 1ns/1ns
module srcs_pin_model #(
    parameter int HOLD = 70
) (
    // clock
    input  wire logic clk_i,
    // request from the bench
    input  wire logic start_i,
    // device side of the pin
    input  wire logic dev_out_i,
    input  wire logic dev_oe_i,
    // wire level seen by all parties
    output logic      pin_o
);
    int cnt_q = 0;

    // hold the wire low for the whole requested time
    always @(posedge clk_i)
    begin
        if (start_i)
            cnt_q <= HOLD;
        else if (cnt_q > 0)
            cnt_q <= cnt_q - 1;
    end

    // pull-up wire: low while either party drives it low
    assign pin_o = !((dev_oe_i && !dev_out_i) || cnt_q > 0);
endmodule // srcs_pin_model

// *** bench/srcs_top_checker.sv ***
// assertions on the reset and clock sequencer ports
`timescale 1ns/1ns
module srcs_top_checker (
    // clock and reset
    input wire logic        clk_i,
    input wire logic        rst_i,
    // sources and pin
    input wire logic        bad_opcode_cause_i,
    input wire logic        bad_address_cause_i,
    input wire logic        opcode_fetch_i,
    input wire logic        reset_pin_i,
    input wire logic        reset_pin_o,
    input wire logic        reset_pin_oe_o,
    // modes and system outputs
    input wire logic        wait_i,
    input wire logic        periph_wait_run_i,
    input wire logic        monitor_mode_i,
    input wire logic        internal_reset_o,
    input wire logic [15:0] reset_vector_o,
    input wire logic        cpu_clk_en_o,
    input wire logic        periph_clk_en_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    logic [12:0] drv_q, drv_d, tail_q, tail_d;
    logic        ext_q, ext_d;

    // ********
    // run lengths of pin drive and reset tail
    // ********
    always_comb
    begin
        drv_d  = reset_pin_oe_o ? drv_q + 13'h1 : 13'h0;
        tail_d = (internal_reset_o && !reset_pin_oe_o) ? tail_q + 13'h1
                                                       : 13'h0;
        ext_d  = internal_reset_o
                 && (ext_q || (!reset_pin_i && !reset_pin_oe_o));
        if (rst_i)
        begin
            drv_d  = 13'h0;
            tail_d = 13'h0;
            ext_d  = 1'b0;
        end
    end

    always_ff @(posedge clk_i)
    begin
        drv_q  <= drv_d;
        tail_q <= tail_d;
        ext_q  <= ext_d;
    end

    chk_por_start: assert property
        ($fell(rst_i) |-> internal_reset_o && reset_pin_oe_o)
        else $error("no hold-off after reset release");
    chk_pin_low: assert property (reset_pin_oe_o |-> !reset_pin_o)
        else $error("pin driven high");
    chk_drive_len: assert property
        ($fell(reset_pin_oe_o) && drv_q < 13'h3e8 |-> drv_q == 13'h20)
        else $error("pin drive length wrong");
    chk_tail_len: assert property
        ($fell(internal_reset_o) && !ext_q |-> tail_q == 13'h20)
        else $error("reset tail length wrong");
    chk_bad_op: assert property
        (bad_opcode_cause_i |=> reset_pin_oe_o && internal_reset_o)
        else $error("bad opcode not taken");
    chk_bad_fetch: assert property
        (bad_address_cause_i && opcode_fetch_i |=> reset_pin_oe_o)
        else $error("bad fetch not taken");
    chk_vec_sel: assert property
        (1'b1 |=> reset_vector_o
            == ($past(monitor_mode_i) ? 16'hfefe : 16'hfffe))
        else $error("reset vector wrong");
    chk_bus_quarter: assert property
        (periph_clk_en_o |=> !periph_clk_en_o [*3])
        else $error("bus enable too frequent");
    chk_wait_cpu: assert property (wait_i |=> !cpu_clk_en_o)
        else $error("cpu clock in wait");
    chk_wait_periph: assert property
        (wait_i && !periph_wait_run_i |=> !periph_clk_en_o)
        else $error("peripheral clock in wait");
    chk_hold_clk: assert property
        (internal_reset_o |-> !cpu_clk_en_o && !periph_clk_en_o)
        else $error("clocks during reset");
endmodule // srcs_top_checker

bind srcs_top srcs_top_checker i_chk (
    .clk_i(clk_i), .rst_i(rst_i), .bad_opcode_cause_i(bad_opcode_cause_i),
    .bad_address_cause_i(bad_address_cause_i),
    .opcode_fetch_i(opcode_fetch_i), .reset_pin_i(reset_pin_i),
    .reset_pin_o(reset_pin_o), .reset_pin_oe_o(reset_pin_oe_o),
    .wait_i(wait_i), .periph_wait_run_i(periph_wait_run_i),
    .monitor_mode_i(monitor_mode_i), .internal_reset_o(internal_reset_o),
    .reset_vector_o(reset_vector_o), .cpu_clk_en_o(cpu_clk_en_o),
    .periph_clk_en_o(periph_clk_en_o)
);

// *** bench/testbench.sv ***
// self-checking bench for the reset and clock sequencer
`timescale 1ns/1ns
`include "srcs_regs.svh"
module testbench;
    logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0;
    logic        we = 1'b0, brown = 1'b0, wdog = 1'b0, bad_op = 1'b0;
    logic        bad_adr = 1'b0, fetch = 1'b0, stop = 1'b0, wake = 1'b0;
    logic        wt = 1'b0, prun = 1'b0, mon = 1'b0, brk = 1'b0;
    logic        ext = 1'b0, pin, ack, pin_o, pin_oe, internal_reset, cpu_en;
    logic        per_en, bce;
    logic [17:0] adr = 18'h0;
    logic [31:0] dat = 32'h0, dat_o, rd;
    logic [15:0] vec;
    logic [7:0]  cause = 8'h80;
    int          bad_count = 0, checks_done = 0, n;

    srcs_top i_dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(dat),
        .wb_dat_o(dat_o), .wb_ack_o(ack), .power_on_pulse_i(1'b0),
        .brownout_cause_i(brown), .watchdog_cause_i(wdog),
        .bad_opcode_cause_i(bad_op), .bad_address_cause_i(bad_adr),
        .opcode_fetch_i(fetch), .reset_pin_i(pin), .reset_pin_o(pin_o),
        .reset_pin_oe_o(pin_oe), .stop_req_i(stop), .wake_i(wake),
        .wait_i(wt), .periph_wait_run_i(prun), .monitor_mode_i(mon),
        .break_wait_set_i(brk), .internal_reset_o(internal_reset),
        .reset_vector_o(vec), .cpu_clk_en_o(cpu_en),
        .periph_clk_en_o(per_en), .break_clear_enable_o(bce)
    );
    srcs_pin_model i_pin (
        .clk_i(clk_i), .start_i(ext), .dev_out_i(pin_o),
        .dev_oe_i(pin_oe), .pin_o(pin)
    );

    initial
    begin
        forever #50 clk_i = ~clk_i;
    end

    // ********
    // shared tasks
    // ********
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask

    task automatic tick(input int c);
        repeat (c) @(posedge clk_i);
    endtask

    task automatic wb(input logic w, input logic [15:0] idx,
                      input logic [7:0] wd);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= {idx, 2'b00};
        dat <= {24'h0, wd};
        do
        begin
            @(posedge clk_i);
        end
        while (ack !== 1'b1);
        rd = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic rdc(input logic [15:0] idx, input logic [7:0] exp);
        wb(1'b0, idx, 8'h0);
        check(rd, {24'h0, exp});
    endtask

    // count edges while the flag chosen by lvl (1: pin_oe, 0: internal_reset) stays high
    task automatic run(input logic lvl, input int lim);
        n = 0;
        while (((lvl ? pin_oe : internal_reset) === 1'b1) && n < lim)
        begin
            @(posedge clk_i);
            n++;
        end
    endtask

    task automatic t_por;
        run(1'b1, 5000);
        check(n >= 4096, 1'b1);
        run(1'b0, 100);
        check(n, 32);
        check(vec, 16'hfffe);
        rdc(`SRCS_IDX_RST_CAUSE, 8'h80);
        $display("test power-on done");
    endtask

    task automatic t_regs;
        rdc(16'hfe02, 8'h00);
        wb(1'b1, `SRCS_IDX_RST_CAUSE, 8'hff);
        rdc(`SRCS_IDX_RST_CAUSE, 8'h80);
        wb(1'b1, `SRCS_IDX_BRK_FLAG_CTL, 8'h80);
        rdc(`SRCS_IDX_BRK_FLAG_CTL, 8'h80);
        check(bce, 1'b1);
        brk <= 1'b1;
        @(posedge clk_i);
        brk <= 1'b0;
        rdc(`SRCS_IDX_BRK_STATUS, 8'h02);
        wb(1'b1, `SRCS_IDX_BRK_STATUS, 8'h00);
        rdc(`SRCS_IDX_BRK_STATUS, 8'h00);
        $display("test registers done");
    endtask

    task automatic t_src;
        logic [7:0] bit_of [3] = '{8'h10, 8'h08, 8'h20};
        bad_adr <= 1'b1;
        @(posedge clk_i);
        bad_adr <= 1'b0;
        tick(4);
        check(internal_reset, 1'b0);
        for (int k = 0; k < 3; k++)
        begin
            bad_op  <= (k == 0);
            bad_adr <= (k == 1);
            fetch   <= (k == 1);
            wdog    <= (k == 2);
            @(posedge clk_i);
            {bad_op, bad_adr, fetch, wdog} <= 4'h0;
            n = 0;
            while (pin_oe !== 1'b1 && n < 8)
            begin
                @(posedge clk_i);
                n++;
            end
            run(1'b1, 100);
            check(n, 32);
            run(1'b0, 100);
            check(n, 32);
            cause = cause | bit_of[k];
            rdc(`SRCS_IDX_RST_CAUSE, cause);
        end
        check(bce, 1'b0);
        $display("test internal sources done");
    endtask

    task automatic t_pin;
        ext <= 1'b1;
        @(posedge clk_i);
        ext <= 1'b0;
        tick(20);
        check(internal_reset, 1'b1);
        tick(60);
        run(1'b0, 200);
        check(internal_reset, 1'b0);
        cause = cause | 8'h40;
        rdc(`SRCS_IDX_RST_CAUSE, cause);
        $display("test pin reset done");
    endtask

    task automatic t_stop;
        int lo [2] = '{32, 4096};
        for (int s = 0; s < 2; s++)
        begin
            wb(1'b1, `SRCS_IDX_SEQ_CTRL, {7'h0, s == 0});
            stop <= 1'b1;
            @(posedge clk_i);
            stop <= 1'b0;
            tick(8);
            wake <= 1'b1;
            @(posedge clk_i);
            wake <= 1'b0;
            n = 0;
            while (per_en !== 1'b1 && n < 5000)
            begin
                @(posedge clk_i);
                n++;
            end
            check(n >= lo[s] && n <= lo[s] + 8, 1'b1);
        end
        $display("test stop exit done");
    endtask

    task automatic t_wait;
        int pc, cc;
        for (int m = 0; m < 3; m++)
        begin
            wt   <= (m != 2);
            prun <= (m == 0);
            tick(2);
            pc = 0;
            cc = 0;
            repeat (16)
            begin
                @(posedge clk_i);
                pc += per_en;
                cc += cpu_en;
            end
            check(pc, (m == 1) ? 0 : 4);
            check(cc, (m == 2) ? 4 : 0);
        end
        $display("test wait mode done");
    endtask

    task automatic t_brown;
        mon   <= 1'b1;
        brown <= 1'b1;
        @(posedge clk_i);
        brown <= 1'b0;
        tick(3);
        check(vec, 16'hfefe);
        run(1'b1, 5000);
        check(n >= 4090, 1'b1);
        run(1'b0, 100);
        check(n, 32);
        mon <= 1'b0;
        rdc(`SRCS_IDX_RST_CAUSE, cause | 8'h02);
        $display("test brown-out done");
    endtask

    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial
    begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        t_por;
        t_regs;
        t_src;
        t_pin;
        t_stop;
        t_wait;
        t_brown;
        finish_test;
    end

    initial
    begin
        #2000000;
        bad_count++;
        finish_test;
    end
endmodule // testbench
